// ### inc/serial_config_consts.vh
`ifndef SERIAL_CONFIG_CONSTS_VH
`define SERIAL_CONFIG_CONSTS_VH
// register byte addresses
`define ADDR_SERIAL_PORT_CONFIG 15'h0000
`define ADDR_POWER_MODE_CONTROL 15'h0002
`define ADDR_PART_CLASS 15'h0003
`define ADDR_PART_NUMBER_LO 15'h0004
`define ADDR_PART_NUMBER_HI 15'h0005
`define ADDR_MAKER_CODE_LO 15'h000C
`define ADDR_MAKER_CODE_HI 15'h000D
`define ADDR_STREAMING_ADDRESS_CONTROL 15'h0010
// field positions
`define BIT_SOFT_RESET 7
`define BIT_ASCEND 5
`define BIT_SEPARATE_OUTPUT 4
`define BIT_ADDR_HOLD 0
`define MODE_MSB 1
`define MODE_LSB 0
`define CLASS_MSB 3
// reset and fixed values
`define RST_SERIAL_PORT_CONFIG 8'h30
`define RST_ASCEND 1'h1
// idle pin levels after reset: chip select high, clock and data low
`define SYNC_RST_PINS 3'h4
`define RST_POWER_MODE 2'h0
`define RST_ADDR_HOLD 1'h0
`define MODE_POWER_DOWN 2'h3
// soft reset quiet time
`define SOFT_RESET_NS 750
`define CLK_PERIOD_NS 40
// spi frame
`define SPI_HDR_BITS 16
`define SPI_ADDR_BITS 15
`endif

// ### verilog/spi_pin_sync.v
`timescale 1ns/100ps
// three-stage synchroniser; output changes when stages two and three agree
module spi_pin_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_out
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  genvar i;
  always @(posedge clk) begin
    s1_q <= pin_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (rst) begin
          pin_out[i] <= RST_VAL[i];
        end else if (s2_q[i] == s3_q[i]) begin
          pin_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule // spi_pin_sync

// ### verilog/serial_config_id_registers.v
`timescale 1ns/100ps
`include "serial_config_consts.vh"
module serial_config_id_registers #(
  // identity values are arbitrary
  parameter [3:0] PART_CLASS_CODE = 4'hA,
  parameter [15:0] PART_IDENTITY_CODE = 16'h5A5A,
  parameter [15:0] MAKER_IDENTITY_CODE = 16'h1234
) (
  // clock and reset
  input wire CLK_SYS,
  input wire RST,
  // serial control port
  input wire SCS_N,
  input wire SCLK,
  input wire SDI,
  output reg SDO,
  output reg SDO_OE,
  // device state
  output reg POWER_DOWN,
  output reg DEVICE_RESET,
  output reg [1:0] POWER_MODE
);
  localparam integer QUIET_CYCLES = (`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam ST_IDLE = 2'h0;
  localparam ST_HDR = 2'h1;
  localparam ST_DATA = 2'h2;

  wire [2:0] pins_s;
  wire cs_n_s;
  wire sclk_s;
  wire sdi_s;
  reg sclk_prev_q;
  reg [1:0] state_q;
  reg [4:0] bit_cnt_q;
  reg [15:0] hdr_q;
  reg [7:0] shift_q;
  reg [14:0] addr_q;
  reg rd_q;
  reg soft_rst_q;
  reg [4:0] quiet_cnt_q;
  reg ascend_q;
  reg rsv6_q;
  reg [3:0] rsv_lo_q;
  reg [5:0] mode_rsv_q;
  reg [1:0] mode_q;
  reg [3:0] class_rsv_q;
  reg [6:0] hold_rsv_q;
  reg addr_hold_q;
  reg [7:0] rd_data;
  wire sclk_rise;
  wire sclk_fall;
  wire [7:0] wr_byte;
  wire [14:0] next_addr;
  wire [14:0] hdr_addr;
  wire in_reset;

  // reset to idle levels so no false clock edge follows reset
  spi_pin_sync #(.WIDTH(3), .RST_VAL(`SYNC_RST_PINS)) u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .pin_in({SCS_N, SCLK, SDI}),
    .pin_out(pins_s)
  );
  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdi_s = pins_s[0];
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign wr_byte = {shift_q[6:0], sdi_s};
  assign hdr_addr = {hdr_q[13:0], sdi_s};
  // serial port and control registers held during soft reset
  assign in_reset = RST | soft_rst_q;

  assign next_addr = addr_hold_q ? addr_q : (ascend_q ? addr_q + 15'h0001 : addr_q - 15'h0001);

  always @* begin
    case (addr_q)
      `ADDR_SERIAL_PORT_CONFIG: rd_data = {1'b0, rsv6_q, ascend_q, 1'b1, rsv_lo_q};
      `ADDR_POWER_MODE_CONTROL: rd_data = {mode_rsv_q, mode_q};
      `ADDR_PART_CLASS: rd_data = {class_rsv_q, PART_CLASS_CODE};
      `ADDR_PART_NUMBER_LO: rd_data = PART_IDENTITY_CODE[7:0];
      `ADDR_PART_NUMBER_HI: rd_data = PART_IDENTITY_CODE[15:8];
      `ADDR_MAKER_CODE_LO: rd_data = MAKER_IDENTITY_CODE[7:0];
      `ADDR_MAKER_CODE_HI: rd_data = MAKER_IDENTITY_CODE[15:8];
      `ADDR_STREAMING_ADDRESS_CONTROL: rd_data = {hold_rsv_q, addr_hold_q};
      default: rd_data = 8'h00;
    endcase
  end

  // soft reset pulse stretched over the quiet time
  always @(posedge CLK_SYS) begin
    if (RST) begin
      soft_rst_q <= 1'b0;
      quiet_cnt_q <= 5'h00;
    end else if (soft_rst_q) begin
      if (quiet_cnt_q == 5'h00) begin
        soft_rst_q <= 1'b0;
      end else begin
        quiet_cnt_q <= quiet_cnt_q - 5'h01;
      end
    end else if (state_q == ST_DATA && !rd_q && sclk_rise && bit_cnt_q == 5'h07 &&
                 addr_q == `ADDR_SERIAL_PORT_CONFIG && shift_q[6]) begin
      soft_rst_q <= 1'b1;
      quiet_cnt_q <= QUIET_CYCLES[4:0] - 5'h01;
    end
  end

  always @(posedge CLK_SYS) begin
    if (in_reset) begin
      sclk_prev_q <= 1'b0;
      state_q <= ST_IDLE;
      bit_cnt_q <= 5'h00;
      hdr_q <= 16'h0000;
      shift_q <= 8'h00;
      addr_q <= 15'h0000;
      rd_q <= 1'b0;
      ascend_q <= `RST_ASCEND;
      rsv6_q <= 1'b0;
      rsv_lo_q <= 4'h0;
      mode_rsv_q <= 6'h00;
      mode_q <= `RST_POWER_MODE;
      class_rsv_q <= 4'h0;
      hold_rsv_q <= 7'h00;
      addr_hold_q <= `RST_ADDR_HOLD;
      SDO <= 1'b0;
      SDO_OE <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      if (cs_n_s) begin
        state_q <= ST_IDLE;
        SDO_OE <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            state_q <= ST_HDR;
            bit_cnt_q <= 5'h00;
          end
          ST_HDR: begin
            if (sclk_rise) begin
              hdr_q <= {hdr_q[14:0], sdi_s};
              bit_cnt_q <= bit_cnt_q + 5'h01;
              if (bit_cnt_q == 5'h0F) begin
                rd_q <= hdr_q[14];
                addr_q <= hdr_addr;
                bit_cnt_q <= 5'h00;
                state_q <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            // read data only on the separate output
            if (rd_q && sclk_fall) begin
              SDO_OE <= 1'b1;
              SDO <= rd_data[3'h7 - bit_cnt_q[2:0]];
            end
            if (sclk_rise) begin
              shift_q <= wr_byte;
              bit_cnt_q <= bit_cnt_q + 5'h01;
              if (bit_cnt_q == 5'h07) begin
                bit_cnt_q <= 5'h00;
                addr_q <= next_addr;
                if (!rd_q) begin
                  case (addr_q)
                    `ADDR_SERIAL_PORT_CONFIG: begin
                      rsv6_q <= wr_byte[6];
                      ascend_q <= wr_byte[`BIT_ASCEND];
                      rsv_lo_q <= wr_byte[3:0];
                    end
                    `ADDR_POWER_MODE_CONTROL: begin
                      mode_rsv_q <= wr_byte[7:2];
                      mode_q <= wr_byte[`MODE_MSB:`MODE_LSB];
                    end
                    `ADDR_PART_CLASS: class_rsv_q <= wr_byte[7:4];
                    `ADDR_STREAMING_ADDRESS_CONTROL: begin
                      hold_rsv_q <= wr_byte[7:1];
                      addr_hold_q <= wr_byte[`BIT_ADDR_HOLD];
                    end
                    default: ;
                  endcase
                end
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  always @(posedge CLK_SYS) begin
    if (RST) begin
      POWER_DOWN <= 1'b0;
      DEVICE_RESET <= 1'b1;
      POWER_MODE <= `RST_POWER_MODE;
    end else begin
      DEVICE_RESET <= soft_rst_q;
      POWER_MODE <= soft_rst_q ? `RST_POWER_MODE : mode_q;
      POWER_DOWN <= !soft_rst_q && mode_q == `MODE_POWER_DOWN;
    end
  end
endmodule // serial_config_id_registers

// ### dv/serial_config_id_registers_checker.sv
`timescale 1ns/100ps
module serial_config_id_registers_checker (
  // watched ports
  input wire CLK_SYS, RST, SCS_N, SCLK, SDI, SDO, SDO_OE, POWER_DOWN, DEVICE_RESET,
  input wire [1:0] POWER_MODE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  reg [4:0] cnt_q;
  wire [4:0] cnt_d = (DEVICE_RESET && !RST) ? cnt_q + 5'h01 : 5'h00;
  always @(posedge CLK_SYS) cnt_q <= cnt_d;
  sequence s_cs_idle; SCS_N [*6]; endsequence
  sequence s_cs_busy; !SCS_N [*6]; endsequence
  sequence s_clk_high; SCLK [*6]; endsequence
  a_reset_flags_set: assert property (RST |=> DEVICE_RESET && POWER_MODE == 2'h0)
    else $error("reset flags wrong");
  a_reset_drive_off: assert property (RST |=> !SDO_OE && !POWER_DOWN)
    else $error("outputs active in reset");
  a_pd_follows_mode: assert property (disable iff (RST) POWER_MODE == 2'h3 |-> ##[0:1] POWER_DOWN)
    else $error("power down missing");
  a_pd_off_normal: assert property (disable iff (RST) POWER_MODE != 2'h3 |-> ##[0:1] !POWER_DOWN)
    else $error("power down unexpected");
  a_soft_clears_mode: assert property (disable iff (RST) $rose(DEVICE_RESET) |-> ##[0:2] POWER_MODE == 2'h0)
    else $error("mode kept in soft reset");
  a_quiet_time_min: assert property (disable iff (RST) $fell(DEVICE_RESET) && cnt_q > 5'h02 |-> cnt_q >= 5'h13)
    else $error("quiet time short");
  a_quiet_time_max: assert property (disable iff (RST) cnt_q <= 5'h15)
    else $error("quiet time long");
  a_idle_no_drive: assert property (disable iff (RST) s_cs_idle |-> !SDO_OE)
    else $error("output driven while idle");
  a_oe_stands_frame: assert property (disable iff (RST) s_cs_busy |-> !$fell(SDO_OE))
    else $error("output enable dropped in frame");
  a_sdo_holds_high: assert property (disable iff (RST) s_clk_high |-> $stable(SDO))
    else $error("read data moved while clock high");
  a_quiet_no_drive: assert property (disable iff (RST) DEVICE_RESET [*3] |-> !SDO_OE)
    else $error("output driven in soft reset");
endmodule // serial_config_id_registers_checker
bind serial_config_id_registers serial_config_id_registers_checker chk_i (.CLK_SYS(CLK_SYS), .RST(RST),
  .SCS_N(SCS_N), .SCLK(SCLK), .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE), .POWER_DOWN(POWER_DOWN),
  .DEVICE_RESET(DEVICE_RESET), .POWER_MODE(POWER_MODE));

// ### dv/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
  // clock
  input wire clk,
  // serial lines
  input wire SDO,
  output reg SCS_N = 1'b1,
  output reg SCLK = 1'b0,
  output reg SDI = 1'b0
);
  task bit_io(input b, output s);
    begin
      SDI <= b;
      repeat (8) @(posedge clk);
      SCLK <= 1'b1;
      s = SDO;
      repeat (8) @(posedge clk);
      SCLK <= 1'b0;
    end
  endtask
  task xfer(input rw, input [14:0] a, input integer n, input [31:0] wd, output [31:0] rd);
    integer i;
    reg s;
    reg [15:0] hdr;
    begin
      rd = 32'h0;
      hdr = {rw, a};
      SCS_N <= 1'b0;
      for (i = 15; i >= 0; i = i - 1)
        bit_io(hdr[i], s);
      for (i = 8 * n - 1; i >= 0; i = i - 1) begin
        bit_io(wd[i], s);
        rd = {rd[30:0], s};
      end
      repeat (8) @(posedge clk);
      SCS_N <= 1'b1;
      // released data line no longer shows last bit
      SDI <= ~SDI;
      repeat (8) @(posedge clk);
    end
  endtask
endmodule // spi_host_model

// ### dv/test_serial_config_id_registers.sv
`timescale 1ns/100ps
module test_serial_config_id_registers;
  reg CLK_SYS;
  reg RST = 1'b1;
  wire SCS_N, SCLK, SDI, SDO, SDO_OE, POWER_DOWN, DEVICE_RESET;
  wire [1:0] POWER_MODE;
  integer mismatches = 0;
  integer compares = 0;
  reg [31:0] d;
  serial_config_id_registers dut (.CLK_SYS(CLK_SYS), .RST(RST), .SCS_N(SCS_N), .SCLK(SCLK), .SDI(SDI),
    .SDO(SDO), .SDO_OE(SDO_OE), .POWER_DOWN(POWER_DOWN), .DEVICE_RESET(DEVICE_RESET), .POWER_MODE(POWER_MODE));
  spi_host_model h (.clk(CLK_SYS), .SDO(SDO), .SCS_N(SCS_N), .SCLK(SCLK), .SDI(SDI));
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task rd(input [14:0] a, input integer n, input [31:0] e);
    begin
      h.xfer(1'b1, a, n, 32'h0, d);
      chk(d, e);
    end
  endtask
  task wr(input [14:0] a, input integer n, input [31:0] v);
    h.xfer(1'b0, a, n, v, d);
  endtask
  task t_defaults;
    begin
      rd(15'h0000, 1, 32'h30);
      rd(15'h0002, 1, 32'h00);
      rd(15'h0003, 1, 32'h0A);
      rd(15'h0004, 2, 32'h5A5A);
      rd(15'h000C, 2, 32'h3412);
      rd(15'h0010, 1, 32'h00);
      rd(15'h0001, 1, 32'h00);
      $display("defaults done");
    end
  endtask
  task t_read_only;
    begin
      wr(15'h0003, 3, 32'h00FFFF);
      rd(15'h0003, 3, 32'h0A5A5A);
      wr(15'h0000, 1, 32'h00);
      rd(15'h0000, 1, 32'h10);
      $display("read only done");
    end
  endtask
  task t_descend_hold;
    begin
      rd(15'h000D, 3, 32'h123400);
      wr(15'h0011, 2, 32'h0001);
      rd(15'h000C, 3, 32'h343434);
      $display("descend hold done");
    end
  endtask
  task t_mode;
    begin
      wr(15'h0002, 1, 32'h03);
      rd(15'h0002, 1, 32'h03);
      chk(POWER_DOWN, 1'b1);
      chk(POWER_MODE, 2'h3);
      $display("mode done");
    end
  endtask
  task t_soft_reset;
    begin
      wr(15'h0000, 1, 32'h80);
      chk(DEVICE_RESET, 1'b1);
      repeat (20) @(posedge CLK_SYS);
      chk(DEVICE_RESET, 1'b0);
      rd(15'h0000, 1, 32'h30);
      rd(15'h0010, 1, 32'h00);
      chk(POWER_MODE, 2'h0);
      chk(POWER_DOWN, 1'b0);
      chk(SDO_OE, 1'b0);
      $display("soft reset done");
    end
  endtask
  task test_done;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (6) @(posedge CLK_SYS);
    t_defaults;
    t_read_only;
    t_descend_hold;
    t_mode;
    t_soft_reset;
    test_done;
  end
  initial begin
    repeat (60000) @(posedge CLK_SYS);
    mismatches = mismatches + 1;
    test_done;
  end
endmodule // test_serial_config_id_registers
